//--- rtl/sbc_field_regs.svh
`ifndef SBC_FIELD_REGS_SVH
`define SBC_FIELD_REGS_SVH

// register addresses carried in the frame
`define ADDR_MODE 7'h01
`define ADDR_HWC 7'h02
`define ADDR_WDC 7'h03
`define ADDR_BUS1 7'h04
`define ADDR_BUS2 7'h05
`define ADDR_EXTWK 7'h07

// frame layout, first bit on the wire is the write flag
`define FRAME_BITS 5'h10
`define ADDR_BITS 5'h08
`define FRM_WR 15
`define FRM_ADDR 14:8
`define FRM_DATA 7:0
`define FRM_ADDR_NXT 6:0

// reset values
`define HWC_POR 8'h00
`define HWC_SOFT_KEEP 8'hc9
`define WDC_RST 8'h00
`define BUS1_RST 8'h20
`define BUS2_RST 8'h00
`define EXTWK_RST 8'h07

// host-writable bits, everything else reads zero
`define HWC_WMASK 8'hfb
`define WDC_WMASK 8'hf7
`define BUS1_WMASK 8'hff
`define BUS2_WMASK 8'h20
`define EXTWK_WMASK 8'ha7

// fail-safe loads
`define BUS1_FS_KEEP 8'he0
`define BUS1_FS_VAL 8'h09
`define EXTWK_FS_KEEP 8'ha0
`define EXTWK_FS_VAL 8'h07

// field positions
`define HWC_VCFG 7
`define HWC_FO 5
`define HWC_LS 3
`define WDC_STOPDIS 6
`define WDC_TYPE 5
`define WDC_BUSWK 4
`define WDC_RSVD 3
`define WDC_PER 2:0
`define BUS1_FLASH 7
`define BUS1_LSM 6
`define BUS1_TXTO 5
`define BUS1_LIN 4:3
`define BUS1_SWK 2
`define BUS1_CAN 1:0
`define BUS2_PEAK 5
`define EXTWK_INTG 7
`define MODE_FLD 7:6

// encodings
`define CAN_NORMAL 2'h3
`define CAN_RXONLY 2'h2
`define CAN_WAKE 2'h1
`define MODE_SLEEP 2'h1

`endif

//--- rtl/sbc_ctrl_pkg.sv
`include "sbc_field_regs.svh"

package sbc_ctrl_pkg;

    typedef enum logic {LINK_IDLE, LINK_SHIFT} link_phase_t;

    typedef struct packed {
        link_phase_t phase;
        logic [4:0] bitCnt;
        logic [15:0] shiftIn;
        logic [7:0] shiftOut;
        logic sclkPrev;
        logic csnPrev;
        logic misoBit;
        logic misoEn;
        logic [7:0] hwc;
        logic [7:0] wdc;
        logic [7:0] bus1;
        logic [7:0] bus2;
        logic [7:0] extwk;
        logic [1:0] modeReq;
        logic modeStb;
        logic spiFail;
        logic wdSetErr;
        logic wdLongWin;
        logic intPulse;
        logic failOut;
    } ctrl_state_t;

endpackage : sbc_ctrl_pkg

//--- rtl/sync_two_ff.sv
`timescale 1ns/1ps

// plain two-stage synchroniser; only the second stage leaves the module
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_state_t;

    sync_state_t s_ff;
    sync_state_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.s1 = din;
        nxt_s.s2 = s_ff.s1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign dout = s_ff.s2;
endmodule : sync_two_ff

//--- rtl/watchdog_bus_mode_control_regs.sv
`timescale 1ns/1ps
`include "sbc_field_regs.svh"

module watchdog_bus_mode_control_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic chipSelectN,
    input wire logic mosi,
    output logic misoOut,
    output logic misoOe,
    input wire logic inStop,
    input wire logic systemErrorFlag,
    input wire logic failureStatus,
    input wire logic enterSleep,
    input wire logic enterStop,
    input wire logic enterRestart,
    input wire logic enterFailSafe,
    input wire logic softReset,
    input wire logic busWakeInStop,
    input wire logic wakeEvent,
    input wire logic statusEvent,
    input wire logic wdStopDisableLoad,
    input wire logic wdStopDisableVal,
    input wire logic wdPeriodLoad,
    input wire logic [2:0] wdPeriodVal,
    input wire logic linModeLoad,
    input wire logic [1:0] linModeVal,
    input wire logic canModeLoad,
    input wire logic [1:0] canModeVal,
    output logic failureOutputs,
    output logic auxRegulatorVoltageCfg,
    output logic auxRegulatorLoadSharing,
    output logic wdStopDisableLo,
    output logic wdTypeSelect,
    output logic wdStartOnBusWake,
    output logic [2:0] wdPeriodCode,
    output logic wdLongWindowStart,
    output logic wdSettingError,
    output logic linFlash,
    output logic linLowSlope,
    output logic linTxTimeoutEnable,
    output logic [1:0] linMode,
    output logic [1:0] canMode,
    output logic selectiveWake,
    output logic peakCurrentThresholdSel,
    output logic intGlobal,
    output logic [1:0] modeRequest,
    output logic modeRequestStrobe,
    output logic spiFail,
    output logic interruptPulse
);
    import sbc_ctrl_pkg::*;

    ctrl_state_t s_ff;
    ctrl_state_t nxt_s;
    logic [2:0] pinSync;
    logic sclkS;
    logic csnS;
    logic mosiS;
    logic sclkRise;
    logic sclkFall;
    logic csnRise;
    logic csnFall;
    logic frameDone;
    logic wrCommit;
    logic [6:0] wrAddr;
    logic [7:0] wrData;

    // link pins come from the host clock domain; chip select goes through
    // inverted so the cleared stages match its idle level and no false
    // frame start follows reset
    sync_two_ff #(
        .WIDTH(3)
    ) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .din({sclk, ~chipSelectN, mosi}),
        .dout(pinSync)
    );

    assign sclkS = pinSync[2];
    assign csnS = ~pinSync[1];
    assign mosiS = pinSync[0];
    assign sclkRise = sclkS & ~s_ff.sclkPrev;
    assign sclkFall = ~sclkS & s_ff.sclkPrev;
    assign csnRise = csnS & ~s_ff.csnPrev;
    assign csnFall = ~csnS & s_ff.csnPrev;
    assign frameDone = csnRise && (s_ff.phase == LINK_SHIFT)
        && (s_ff.bitCnt == `FRAME_BITS);
    assign wrCommit = frameDone && s_ff.shiftIn[`FRM_WR];
    assign wrAddr = s_ff.shiftIn[`FRM_ADDR];
    assign wrData = s_ff.shiftIn[`FRM_DATA];

    function automatic logic [7:0] readReg(input logic [6:0] addr,
                                           input ctrl_state_t st);
        logic [7:0] r;
        r = 8'h00;
        unique case (addr)
            `ADDR_HWC: r = st.hwc;
            `ADDR_WDC: r = st.wdc;
            `ADDR_BUS1: r = st.bus1;
            `ADDR_BUS2: r = st.bus2;
            `ADDR_EXTWK: r = st.extwk;
            default: r = 8'h00;
        endcase
        return r;
    endfunction : readReg

    always_comb begin
        nxt_s = s_ff;
        nxt_s.sclkPrev = sclkS;
        nxt_s.csnPrev = csnS;
        nxt_s.modeStb = 1'b0;
        nxt_s.spiFail = 1'b0;
        nxt_s.wdSetErr = 1'b0;
        nxt_s.wdLongWin = 1'b0;
        nxt_s.intPulse = 1'b0;

        // frame shifting, mode 0: sample on rise, shift out on fall
        unique case (s_ff.phase)
            LINK_IDLE: begin
                if (csnFall) begin
                    nxt_s.phase = LINK_SHIFT;
                    nxt_s.bitCnt = 5'h00;
                    nxt_s.shiftOut = 8'h00;
                    nxt_s.misoBit = 1'b0;
                    nxt_s.misoEn = 1'b1;
                end
            end
            LINK_SHIFT: begin
                if (csnRise) begin
                    nxt_s.phase = LINK_IDLE;
                    nxt_s.misoEn = 1'b0;
                    // a clipped or overlong frame is dropped whole, but at 48 bits the 5-bit count wraps to 16 and it is taken
                    if (s_ff.bitCnt != `FRAME_BITS) begin
                        nxt_s.spiFail = 1'b1;
                    end
                end else if (sclkRise && s_ff.bitCnt != `FRAME_BITS) begin
                    nxt_s.shiftIn = {s_ff.shiftIn[14:0], mosiS};
                    nxt_s.bitCnt = s_ff.bitCnt + 5'h01;
                    if (s_ff.bitCnt + 5'h01 == `ADDR_BITS) begin
                        nxt_s.shiftOut = readReg(
                            nxt_s.shiftIn[`FRM_ADDR_NXT], s_ff);
                    end
                end else if (sclkRise) begin
                    nxt_s.bitCnt = s_ff.bitCnt + 5'h01;
                end else if (sclkFall) begin
                    nxt_s.misoBit = s_ff.shiftOut[7];
                    nxt_s.shiftOut = {s_ff.shiftOut[6:0], 1'b0};
                end
            end
        endcase

        // host writes, applied at chip select rise
        if (wrCommit) begin
            unique case (wrAddr)
                `ADDR_MODE: begin
                    if (inStop && wrData[`MODE_FLD] == `MODE_SLEEP) begin
                        nxt_s.spiFail = 1'b1;
                    end else begin
                        nxt_s.modeReq = wrData[`MODE_FLD];
                        nxt_s.modeStb = 1'b1;
                    end
                end
                `ADDR_HWC: nxt_s.hwc = wrData & `HWC_WMASK;
                `ADDR_WDC: begin
                    if (^wrData) begin
                        nxt_s.wdSetErr = 1'b1;
                    end else begin
                        nxt_s.wdc = wrData & `WDC_WMASK;
                    end
                end
                `ADDR_BUS1: nxt_s.bus1 = wrData & `BUS1_WMASK;
                `ADDR_BUS2: begin
                    // stop mode drops the write with no fail flag
                    if (!inStop) begin
                        nxt_s.bus2 = wrData & `BUS2_WMASK;
                    end
                end
                `ADDR_EXTWK: nxt_s.extwk = wrData & `EXTWK_WMASK;
                default: nxt_s.spiFail = 1'b1;
            endcase
        end

        // device-side updates win over a host write in the same cycle
        if (wdStopDisableLoad) begin
            nxt_s.wdc[`WDC_STOPDIS] = wdStopDisableVal;
        end
        if (wdPeriodLoad) begin
            nxt_s.wdc[`WDC_PER] = wdPeriodVal;
        end
        if (linModeLoad) begin
            nxt_s.bus1[`BUS1_LIN] = linModeVal;
        end
        if (canModeLoad) begin
            nxt_s.bus1[`BUS1_CAN] = canModeVal;
        end
        if (enterSleep) begin
            if (!systemErrorFlag && s_ff.bus1[`BUS1_CAN] == `CAN_NORMAL) begin
                nxt_s.bus1[`BUS1_CAN] = `CAN_WAKE;
            end
            if (s_ff.bus1[`BUS1_CAN] == `CAN_RXONLY) begin
                nxt_s.bus1[`BUS1_CAN] = `CAN_WAKE;
            end
        end
        if (enterFailSafe) begin
            nxt_s.bus1 = (s_ff.bus1 & `BUS1_FS_KEEP) | `BUS1_FS_VAL;
            nxt_s.extwk = (s_ff.extwk & `EXTWK_FS_KEEP) | `EXTWK_FS_VAL;
        end
        if (softReset) begin
            nxt_s.hwc = s_ff.hwc & `HWC_SOFT_KEEP;
            nxt_s.wdc = `WDC_RST;
            nxt_s.bus1 = `BUS1_RST;
            nxt_s.bus2 = `BUS2_RST;
            nxt_s.extwk = `EXTWK_RST;
        end
        if (enterRestart) begin
            nxt_s.hwc[`HWC_FO] = 1'b0;
        end

        if (busWakeInStop && s_ff.wdc[`WDC_BUSWK]) begin
            nxt_s.wdLongWin = 1'b1;
        end
        nxt_s.intPulse = wakeEvent
            || (statusEvent && s_ff.extwk[`EXTWK_INTG]);
        // the failure flag holds a failure-driven output on; clearing the software bit drops it only while the flag is low
        nxt_s.failOut = failureStatus || nxt_s.hwc[`HWC_FO];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_ff <= '0;
            s_ff.sclkPrev <= 1'b0;
            s_ff.csnPrev <= 1'b1;
            s_ff.hwc <= `HWC_POR;
            s_ff.wdc <= `WDC_RST;
            s_ff.bus1 <= `BUS1_RST;
            s_ff.bus2 <= `BUS2_RST;
            s_ff.extwk <= `EXTWK_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign misoOut = s_ff.misoBit;
    assign misoOe = s_ff.misoEn;
    assign failureOutputs = s_ff.failOut;
    assign auxRegulatorVoltageCfg = s_ff.hwc[`HWC_VCFG];
    assign auxRegulatorLoadSharing = s_ff.hwc[`HWC_LS];
    assign wdStopDisableLo = s_ff.wdc[`WDC_STOPDIS];
    assign wdTypeSelect = s_ff.wdc[`WDC_TYPE];
    assign wdStartOnBusWake = s_ff.wdc[`WDC_BUSWK];
    assign wdPeriodCode = s_ff.wdc[`WDC_PER];
    assign wdLongWindowStart = s_ff.wdLongWin;
    assign wdSettingError = s_ff.wdSetErr;
    assign linFlash = s_ff.bus1[`BUS1_FLASH];
    assign linLowSlope = s_ff.bus1[`BUS1_LSM];
    assign linTxTimeoutEnable = s_ff.bus1[`BUS1_TXTO];
    assign linMode = s_ff.bus1[`BUS1_LIN];
    assign canMode = s_ff.bus1[`BUS1_CAN];
    assign selectiveWake = s_ff.bus1[`BUS1_SWK];
    assign peakCurrentThresholdSel = s_ff.bus2[`BUS2_PEAK];
    assign intGlobal = s_ff.extwk[`EXTWK_INTG];
    assign modeRequest = s_ff.modeReq;
    assign modeRequestStrobe = s_ff.modeStb;
    assign spiFail = s_ff.spiFail;
    assign interruptPulse = s_ff.intPulse;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_wdc_write;
        wrCommit && wrAddr == `ADDR_WDC && !wdStopDisableLoad
            && !wdPeriodLoad && !softReset;
    endsequence

    property p_fail_hold;
        failureStatus |=> failureOutputs;
    endproperty
    a_fail_hold: assert property (p_fail_hold)
        else $error("failure outputs dropped while failure flag set");

    property p_restart_fo;
        enterRestart |=> !s_ff.hwc[`HWC_FO]
            && failureOutputs == $past(failureStatus);
    endproperty
    a_restart_fo: assert property (p_restart_fo)
        else $error("restart did not clear software failure enable");

    property p_soft_keep;
        softReset && !enterRestart
            |=> s_ff.hwc == ($past(s_ff.hwc) & `HWC_SOFT_KEEP);
    endproperty
    a_soft_keep: assert property (p_soft_keep)
        else $error("soft reset value of hardware control wrong");

    property p_parity;
        s_wdc_write ##0 (^wrData) |=> wdSettingError && $stable(s_ff.wdc);
    endproperty
    a_parity: assert property (p_parity)
        else $error("odd parity watchdog write was accepted");

    property p_rsvd;
        s_ff.wdc[`WDC_RSVD] == 1'b0 && (s_ff.bus2 & ~`BUS2_WMASK) == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit reads nonzero");

    property p_sleep_can;
        enterSleep && !systemErrorFlag && !canModeLoad && !softReset
            && !enterFailSafe && canMode == `CAN_NORMAL
            |=> canMode == `CAN_WAKE && $stable(selectiveWake);
    endproperty
    a_sleep_can: assert property (p_sleep_can)
        else $error("sleep entry did not set CAN wake capable");

    property p_stop_rx;
        enterStop && !enterSleep && !canModeLoad && !softReset && !wrCommit
            && !enterFailSafe && canMode == `CAN_RXONLY
            |=> canMode == `CAN_RXONLY;
    endproperty
    a_stop_rx: assert property (p_stop_rx)
        else $error("stop entry changed receive-only CAN mode");

    property p_failsafe;
        enterFailSafe && !softReset |=> s_ff.bus1[4:0] == 5'h09
            && s_ff.extwk[6:0] == (`EXTWK_FS_VAL | ($past(s_ff.extwk) & 8'h20));
    endproperty
    a_failsafe: assert property (p_failsafe)
        else $error("fail-safe load of wake registers wrong");

    property p_peak_stop;
        wrCommit && wrAddr == `ADDR_BUS2 && inStop && !softReset
            |=> $stable(s_ff.bus2) && !spiFail;
    endproperty
    a_peak_stop: assert property (p_peak_stop)
        else $error("peak threshold changed or failed in stop");

    property p_stop_sleep;
        wrCommit && wrAddr == `ADDR_MODE && inStop
            && wrData[`MODE_FLD] == `MODE_SLEEP
            |=> spiFail && !modeRequestStrobe;
    endproperty
    a_stop_sleep: assert property (p_stop_sleep)
        else $error("stop to sleep command was not rejected");

    property p_int;
        (wakeEvent || (statusEvent && intGlobal)) |=> interruptPulse;
    endproperty
    a_int: assert property (p_int)
        else $error("interrupt not raised for enabled event");
endmodule : watchdog_bus_mode_control_regs

//--- verif/spi_host_model.sv
`timescale 1ns/1ps

// spi mode 0 host; the link clock stands low outside frames
module spi_host_model (
    output logic sclk,
    output logic chipSelectN,
    output logic mosi,
    input wire logic misoOut
);
    initial begin
        sclk = 1'b0;
        chipSelectN = 1'b1;
        mosi = 1'b0;
    end

    // n below 16 sends a short frame on purpose
    task automatic xfer(input logic [15:0] w, input int n,
                        output logic [7:0] rd);
        rd = 8'h00;
        chipSelectN = 1'b0;
        #62.5;
        for (int i = 15; i > 15 - n; i--) begin
            mosi = w[i];
            #62.5 sclk = 1'b1;
            if (i < 8) begin
                rd[i] = misoOut;
            end
            #62.5 sclk = 1'b0;
        end
        #62.5 chipSelectN = 1'b1;
        // data line no longer meaningful, so it must not hold its level
        mosi = ~mosi;
    endtask : xfer
endmodule : spi_host_model

//--- verif/test_watchdog_bus_mode_control_regs.sv
`timescale 1ns/1ps

module test_watchdog_bus_mode_control_regs;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sclk, chipSelectN, mosi, misoOut, misoOe;
    logic inStop = 1'b0;
    logic systemErrorFlag = 1'b0;
    logic failureStatus = 1'b0;
    logic [11:0] ev = 12'h000;
    logic wdStopDisableVal = 1'b0;
    logic [2:0] wdPeriodVal = 3'h0;
    logic [1:0] linModeVal = 2'h0, canModeVal = 2'h0;
    logic failureOutputs, auxRegulatorVoltageCfg, auxRegulatorLoadSharing;
    logic wdStopDisableLo, wdTypeSelect, wdStartOnBusWake;
    logic [2:0] wdPeriodCode;
    logic wdLongWindowStart, wdSettingError, linFlash, linLowSlope;
    logic linTxTimeoutEnable, selectiveWake, peakCurrentThresholdSel;
    logic [1:0] linMode, canMode, modeRequest;
    logic intGlobal, modeRequestStrobe, spiFail, interruptPulse;
    int bad_count = 0;
    int checks_done = 0;
    int seed = 53871;
    int nLong = 0, nErr = 0, nStb = 0, nFail = 0, nInt = 0, n0 = 0;
    logic [7:0] d, r, e;

    always #5 clk = ~clk;

    watchdog_bus_mode_control_regs DUT (
        .clk, .rst, .sclk, .chipSelectN, .mosi, .misoOut, .misoOe, .inStop,
        .systemErrorFlag, .failureStatus, .enterSleep(ev[0]),
        .enterStop(ev[1]), .enterRestart(ev[2]), .enterFailSafe(ev[3]),
        .softReset(ev[4]), .busWakeInStop(ev[5]), .wakeEvent(ev[6]),
        .statusEvent(ev[7]), .wdStopDisableLoad(ev[8]), .wdStopDisableVal,
        .wdPeriodLoad(ev[9]), .wdPeriodVal, .linModeLoad(ev[10]),
        .linModeVal, .canModeLoad(ev[11]), .canModeVal, .failureOutputs,
        .auxRegulatorVoltageCfg, .auxRegulatorLoadSharing, .wdStopDisableLo,
        .wdTypeSelect, .wdStartOnBusWake, .wdPeriodCode, .wdLongWindowStart,
        .wdSettingError, .linFlash, .linLowSlope, .linTxTimeoutEnable,
        .linMode, .canMode, .selectiveWake, .peakCurrentThresholdSel,
        .intGlobal, .modeRequest, .modeRequestStrobe, .spiFail,
        .interruptPulse
    );

    spi_host_model host (.sclk, .chipSelectN, .mosi, .misoOut);

    // pulse outputs are counted so scenarios can compare deltas
    always @(posedge clk) begin
        if (wdLongWindowStart === 1'b1) nLong <= nLong + 1;
        if (wdSettingError === 1'b1) nErr <= nErr + 1;
        if (modeRequestStrobe === 1'b1) nStb <= nStb + 1;
        if (spiFail === 1'b1) nFail <= nFail + 1;
        if (interruptPulse === 1'b1) nInt <= nInt + 1;
    end

    function automatic logic [7:0] wdWord(input logic [7:0] v);
        return {^v[6:0], v[6:0]};
    endfunction : wdWord

    // sleep entry: normal and receive-only fall back to wake capable
    function automatic logic [7:0] sleepBus(input logic [7:0] v);
        return (v[1] === 1'b1) ? {v[7:2], 2'b01} : v;
    endfunction : sleepBus

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [6:0] a, output logic [7:0] q);
        host.xfer({1'b0, a, 8'h00}, 16, q);
        repeat (8) @(posedge clk);
        #1;
    endtask : rd

    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] q;
        host.xfer({1'b1, a, v}, 16, q);
        repeat (8) @(posedge clk);
        #1;
    endtask : wr

    task automatic rchk(input logic [6:0] a, input logic [7:0] exp,
                        input string msg);
        logic [7:0] q;
        rd(a, q);
        chk(q, exp, msg);
    endtask : rchk

    task automatic pulse(input int i);
        @(posedge clk);
        #1 ev[i] = 1'b1;
        @(posedge clk);
        #1 ev[i] = 1'b0;
        @(posedge clk);
        #1;
    endtask : pulse

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    initial begin
        #500000;
        bad_count++;
        $display("BAD t=%0t run did not finish", $time);
        test_done();
    end

    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        rchk(7'h03, 8'h00, "wdc reset");
        rchk(7'h04, 8'h20, "bus1 reset");
        rchk(7'h05, 8'h00, "bus2 reset");
        chk({7'h0, misoOe}, 8'h00, "miso idle");
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            r = wdWord(8'($random(seed)));
            wr(7'h03, r);
            rchk(7'h03, r & 8'hf7, "wdc readback");
            chk({1'b0, wdStopDisableLo, wdTypeSelect, wdStartOnBusWake, 1'b0,
                 wdPeriodCode}, r & 8'h77, "wdc fields");
        end
        wr(7'h03, r ^ 8'h01);
        rchk(7'h03, r & 8'hf7, "odd parity kept");
        chk(8'(nErr), 8'h01, "parity error pulse");
        wr(7'h03, wdWord(8'h10));
        pulse(5);
        chk(8'(nLong), 8'h01, "long window start");
        wr(7'h03, 8'h00);
        pulse(5);
        chk(8'(nLong), 8'h01, "no start on wake");
        wdStopDisableVal = 1'b1;
        wdPeriodVal = 3'h5;
        pulse(8);
        pulse(9);
        rd(7'h03, d);
        chk(d & 8'h7f, 8'h45, "wdc device loads");
        $display("test watchdog done");
        for (int i = 0; i < 8; i++) begin
            r = {3'($random(seed)), 2'(i), 3'(i)};
            wr(7'h04, r);
            rchk(7'h04, r, "bus1 readback");
            chk({linFlash, linLowSlope, linTxTimeoutEnable, linMode,
                 selectiveWake, canMode}, r, "bus1 fields");
        end
        e = r ^ 8'h40;
        host.xfer({1'b1, 7'h04, e}, 16, d);
        chk({7'h0, linLowSlope}, {7'h0, r[6]}, "slope before cs");
        repeat (8) @(posedge clk);
        #1;
        chk({7'h0, linLowSlope}, {7'h0, e[6]}, "slope after cs");
        wr(7'h04, 8'h07);
        canModeVal = 2'h2;
        linModeVal = 2'h1;
        pulse(11);
        pulse(10);
        rchk(7'h04, 8'h0e, "device mode loads");
        for (int i = 0; i < 8; i++) begin
            r = {5'h0, 3'(i)};
            wr(7'h04, r);
            pulse(0);
            rchk(7'h04, sleepBus(r), "sleep can");
            wr(7'h04, r);
            pulse(1);
            rchk(7'h04, r, "stop can");
        end
        $display("test bus modes done");
        n0 = nInt;
        pulse(7);
        chk(8'(nInt - n0), 8'h00, "status masked");
        pulse(6);
        chk(8'(nInt - n0), 8'h01, "wake interrupt");
        r = 8'($random(seed));
        wr(7'h04, r);
        wr(7'h07, 8'h80);
        pulse(3);
        rchk(7'h04, (r & 8'he0) | 8'h09, "failsafe bus1");
        rchk(7'h07, 8'h87, "failsafe wake");
        n0 = nInt;
        pulse(7);
        chk(8'(nInt - n0), 8'h01, "status global");
        $display("test events done");
        wr(7'h05, 8'hff);
        rchk(7'h05, 8'h20, "bus2 mask");
        inStop = 1'b1;
        n0 = nFail + nInt;
        wr(7'h05, 8'h00);
        rchk(7'h05, 8'h20, "bus2 in stop");
        chk(8'(nFail + nInt - n0), 8'h00, "bus2 silent");
        n0 = nStb;
        wr(7'h01, 8'h40);
        chk(8'(nStb - n0), 8'h00, "stop to sleep");
        inStop = 1'b0;
        wr(7'h01, 8'h80);
        chk(8'(nStb - n0), 8'h01, "mode strobe");
        chk({6'h0, modeRequest}, 8'h02, "mode request");
        n0 = nFail;
        wr(7'h7f, 8'h55);
        rchk(7'h7f, 8'h00, "unmapped read");
        host.xfer({1'b1, 7'h04, 8'hff}, 12, d);
        repeat (8) @(posedge clk);
        #1;
        rchk(7'h04, (r & 8'he0) | 8'h09, "short frame");
        chk(8'(nFail - n0), 8'h02, "spi fail count");
        $display("test access done");
        wr(7'h02, 8'h20);
        chk({7'h0, failureOutputs}, 8'h01, "fo by sw");
        failureStatus = 1'b1;
        wr(7'h02, 8'h00);
        chk({7'h0, failureOutputs}, 8'h01, "fo held");
        failureStatus = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk({7'h0, failureOutputs}, 8'h00, "fo released");
        wr(7'h02, 8'h20);
        pulse(2);
        chk({7'h0, failureOutputs}, 8'h00, "fo restart");
        rchk(7'h02, 8'h00, "fo bit cleared");
        wr(7'h02, 8'hff);
        pulse(4);
        rchk(7'h02, 8'hc9, "soft reset hwc");
        rchk(7'h04, 8'h20, "soft reset bus1");
        chk({6'h0, auxRegulatorVoltageCfg, auxRegulatorLoadSharing}, 8'h03,
            "aux kept");
        #3 rst = 1'b1;
        @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        rchk(7'h02, 8'h00, "por hwc");
        $display("test reset paths done");
        test_done();
    end
endmodule : test_watchdog_bus_mode_control_regs
